/* File: hw/stepper_status_bank.sv */
// status word and register map of a single-channel stepper output module
`include "stepper_status_defines.svh"
`default_nettype none
//
// Contract
// - supply low sets status bit 9 and forces the motor off
// - driver overtemperature sets status bit 8 and forces the motor off
// - encoder lock bit follows feature bits 12/13 and the latch input
// - latch request toggle flips ack bit next cycle; latch data is loaded on the event
// - latch-shown bit tells whether bytes 2,3 carry latch or position
// - latch event flag needs an enable bit; array waits for count
// - target reached flag, only meaningful in path control mode
// - clear or load position command acknowledged once done
// - status bit 1 is input 2, inverted by feature 2 bit 15
// - status bit 0 is input 1, inverted by feature 2 bit 14
// - parameter registers readable over register access; read-only ones ignore writes
// - registers 0-31 fixed, 32-63 chosen by page select
// - page select holds 0 to 2, resets to zero
// - target position is a 32-bit low and high word pair, read/write
module stepper_status_bank #(
  parameter logic [15:0] TYPE_ID    = 16'h0abc, // arbitrary value
  parameter logic [15:0] FW_VERSION = 16'h0101  // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] control_word,
  input  wire logic [7:0]  control_byte,
  input  wire logic        path_control_mode,
  input  wire logic        supply_low,
  input  wire logic        driver_overtemp,
  input  wire logic        encoder_enable,
  input  wire logic        latch_input,
  input  wire logic        latch_event,
  input  wire logic        target_reached,
  input  wire logic        pos_op_done,
  input  wire logic [31:0] actual_pos,
  input  wire logic [15:0] temperature,
  input  wire logic        din1,
  input  wire logic        din2,
  input  wire logic        reg_req,
  input  wire logic        reg_write,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata,
  output var  logic        reg_ack,
  output var  logic [15:0] status_word,
  output var  logic [15:0] data_bytes23,
  output var  logic        motor_off,
  output var  logic        pos_clear,
  output var  logic        pos_load,
  output var  logic [31:0] pos_load_value
);
  logic        fault_uv;
  logic        fault_ot;
  logic        err_ack;
  logic [15:0] page_r, page_nxt;
  logic [15:0] tgt_lo_r, tgt_lo_nxt;
  logic [15:0] tgt_hi_r, tgt_hi_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [15:0] align_r, align_nxt;
  logic [15:0] hwver_r, hwver_nxt;
  logic [15:0] code_r, code_nxt;
  logic [15:0] paged_r [0:2][0:31];
  logic [15:0] paged_nxt [0:2][0:31];
  logic [31:0] latch_val_r, latch_val_nxt;
  logic        req_seen_r, req_seen_nxt;
  logic        tgl_ack_r, tgl_ack_nxt;
  logic        lvalid_r, lvalid_nxt;
  logic [15:0] lcount_r, lcount_nxt;
  logic        shown_r;
  logic [15:0] rdata_r, rdata_nxt;
  logic        ack_r, ack_nxt;
  logic        reg_take;
  stepper_status_pkg::pos_state_t pos_r, pos_nxt;
  logic        feat_lock_lo, feat_lock_hi, feat_array;
  logic        latch_en, pos_cmd;
  logic [15:0] feat1, feat2;
  logic [1:0]  pg;

  assign err_ack = control_byte[`CB_ERR_ACK];
  // latched until acknowledged while the cause is gone
  sticky_fault u_uv (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cond    (supply_low),
    .ack     (err_ack),
    .flag    (fault_uv)
  );
  sticky_fault u_ot (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cond    (driver_overtemp),
    .ack     (err_ack),
    .flag    (fault_ot)
  );
  assign motor_off = fault_uv | fault_ot;

  assign pg      = page_r[1:0];
  assign feat1   = paged_r[0][`FEAT1_IDX];
  assign feat2   = paged_r[0][`FEAT2_IDX];
  assign feat_lock_lo = feat1[`FEAT1_LOCK_LOW];
  assign feat_lock_hi = feat1[`FEAT1_LOCK_HIGH];
  assign feat_array   = feat1[`FEAT1_LATCH_ARRAY];
  assign latch_en = control_word[`CW_LATCH_EN0] |
                    control_word[`CW_LATCH_EN3] |
                    control_word[`CW_LATCH_EN4];
  assign pos_cmd  = control_word[`CW_POS_CLEAR] |
                    control_word[`CW_POS_LOAD];
  // a request is taken while ack is low, so one still held is taken again every other cycle; the host drops it after seeing ack
  assign reg_take = reg_req && !ack_r;
  assign ack_nxt  = reg_take;

  // register writes; read-only and reserved numbers fall through
  always_comb begin
    page_nxt   = page_r;
    tgt_lo_nxt = tgt_lo_r;
    tgt_hi_nxt = tgt_hi_r;
    cmd_nxt    = cmd_r;
    align_nxt  = align_r;
    hwver_nxt  = hwver_r;
    code_nxt   = code_r;
    paged_nxt  = paged_r;
    if (reg_take && reg_write) begin
      if (reg_addr >= `REG_PAGED_BASE) begin
        paged_nxt[pg][reg_addr[4:0]] = reg_wdata;
      end else begin
        unique case (reg_addr)
          `REG_TGT_POS_LO:  tgt_lo_nxt = reg_wdata;
          `REG_TGT_POS_HI:  tgt_hi_nxt = reg_wdata;
          `REG_PAGE_SELECT: begin
            // out-of-range page values are dropped
            if (reg_wdata <= `PAGE_MAX) begin
              page_nxt = reg_wdata;
            end
          end
          `REG_COMMAND:     cmd_nxt   = reg_wdata;
          `REG_ALIGNMENT:   align_nxt = reg_wdata;
          `REG_HW_VERSION:  hwver_nxt = reg_wdata;
          `REG_CODE_WORD:   code_nxt  = reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_take) begin
      rdata_nxt = 16'h0000;
      if (reg_addr >= `REG_PAGED_BASE) begin
        rdata_nxt = paged_r[pg][reg_addr[4:0]];
      end else begin
        unique case (reg_addr)
          `REG_ACT_POS_LO:  rdata_nxt = actual_pos[15:0];
          `REG_ACT_POS_HI:  rdata_nxt = actual_pos[31:16];
          `REG_TGT_POS_LO:  rdata_nxt = tgt_lo_r;
          `REG_TGT_POS_HI:  rdata_nxt = tgt_hi_r;
          `REG_PAGE_SELECT: rdata_nxt = page_r;
          `REG_LATCH_HI:    rdata_nxt = latch_val_r[31:16];
          `REG_TEMPERATURE: rdata_nxt = temperature;
          `REG_COMMAND:     rdata_nxt = cmd_r;
          `REG_TYPE_ID:     rdata_nxt = TYPE_ID;
          `REG_FW_VERSION:  rdata_nxt = FW_VERSION;
          `REG_MUX_SHIFT:   rdata_nxt = `VAL_MUX_SHIFT;
          `REG_SIG_CHAN:    rdata_nxt = `VAL_SIG_CHAN;
          `REG_MIN_DLEN:    rdata_nxt = `VAL_MIN_DLEN;
          `REG_DSTRUCT:     rdata_nxt = `VAL_DSTRUCT;
          `REG_ALIGNMENT:   rdata_nxt = align_r;
          `REG_HW_VERSION:  rdata_nxt = hwver_r;
          `REG_CODE_WORD:   rdata_nxt = code_r;
          default:          rdata_nxt = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_r   <= `RST_PAGE_SELECT;
      tgt_lo_r <= 16'h0000;
      tgt_hi_r <= 16'h0000;
      cmd_r    <= `RST_COMMAND;
      align_r  <= `RST_ALIGNMENT;
      hwver_r  <= `RST_HW_VERSION;
      code_r   <= `RST_CODE_WORD;
      rdata_r  <= 16'h0000;
      ack_r    <= 1'b0;
      for (int p = 0; p < 3; p++) begin
        for (int i = 0; i < 32; i++) begin
          paged_r[p][i] <= 16'h0000;
        end
      end
      paged_r[0][`LATCH_COUNT_IDX] <= `RST_LATCH_COUNT;
    end else begin
      page_r   <= page_nxt;
      tgt_lo_r <= tgt_lo_nxt;
      tgt_hi_r <= tgt_hi_nxt;
      cmd_r    <= cmd_nxt;
      align_r  <= align_nxt;
      hwver_r  <= hwver_nxt;
      code_r   <= code_nxt;
      paged_r  <= paged_nxt;
      rdata_r  <= rdata_nxt;
      ack_r    <= ack_nxt;
    end
  end
  assign reg_rdata = rdata_r;
  assign reg_ack   = ack_r;

  // latch handshake: capture on event, flip ack once data is in place
  always_comb begin
    latch_val_nxt = latch_val_r;
    req_seen_nxt  = control_word[`CW_LATCH_REQ];
    tgl_ack_nxt   = tgl_ack_r;
    lvalid_nxt    = lvalid_r;
    lcount_nxt    = lcount_r;
    if (latch_event && latch_en) begin
      latch_val_nxt = actual_pos;
      if (feat_array) begin
        lcount_nxt = lcount_r + 16'h0001;
        // flag waits for the configured number of stored values
        if (lcount_nxt >= paged_r[0][`LATCH_COUNT_IDX]) begin
          lvalid_nxt = 1'b1;
        end
      end else begin
        lvalid_nxt = 1'b1;
      end
    end
    if (!latch_en) begin
      lvalid_nxt = 1'b0;
      lcount_nxt = 16'h0000;
    end
    if (control_word[`CW_LATCH_REQ] != req_seen_r) begin
      tgl_ack_nxt = control_word[`CW_LATCH_REQ];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_val_r <= 32'h0000_0000;
      req_seen_r  <= 1'b0;
      tgl_ack_r   <= 1'b0;
      lvalid_r    <= 1'b0;
      lcount_r    <= 16'h0000;
      shown_r     <= 1'b0;
    end else begin
      latch_val_r <= latch_val_nxt;
      req_seen_r  <= req_seen_nxt;
      tgl_ack_r   <= tgl_ack_nxt;
      lvalid_r    <= lvalid_nxt;
      lcount_r    <= lcount_nxt;
      shown_r     <= control_word[`CW_LATCH_REQ];
    end
  end

  // bytes 2,3 carry the latch low word while the latch is shown
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_bytes23 <= 16'h0000;
    end else if (control_word[`CW_LATCH_REQ]) begin
      data_bytes23 <= latch_val_r[15:0];
    end else begin
      data_bytes23 <= actual_pos[15:0];
    end
  end

  // position clear/load handshake
  always_comb begin
    pos_nxt = pos_r;
    unique case (pos_r)
      stepper_status_pkg::POS_IDLE: begin
        if (pos_cmd) begin
          pos_nxt = stepper_status_pkg::POS_WAIT;
        end
      end
      stepper_status_pkg::POS_WAIT: begin
        if (pos_op_done) begin
          pos_nxt = stepper_status_pkg::POS_DONE;
        end
      end
      stepper_status_pkg::POS_DONE: begin
        // ack holds until the host drops the command
        if (!pos_cmd) begin
          pos_nxt = stepper_status_pkg::POS_IDLE;
        end
      end
      default: pos_nxt = stepper_status_pkg::POS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= stepper_status_pkg::POS_IDLE;
    end else begin
      pos_r <= pos_nxt;
    end
  end
  assign pos_clear = (pos_r == stepper_status_pkg::POS_WAIT) &&
                     control_word[`CW_POS_CLEAR];
  assign pos_load  = (pos_r == stepper_status_pkg::POS_WAIT) &&
                     control_word[`CW_POS_LOAD] &&
                     !control_word[`CW_POS_CLEAR];
  assign pos_load_value = {tgt_hi_r, tgt_lo_r};

  always_comb begin
    status_word = 16'h0000;
    status_word[`SW_SUPPLY_LOW] = fault_uv;
    status_word[`SW_OVERTEMP]   = fault_ot;
    status_word[`SW_ENC_LOCK]   = !encoder_enable &&
        ((feat_lock_lo && !latch_input) ||
         (feat_lock_hi && latch_input));
    status_word[`SW_LATCH_TGL]   = tgl_ack_r;
    status_word[`SW_LATCH_SHOWN] = shown_r;
    status_word[`SW_LATCH_EVT]   = lvalid_r;
    status_word[`SW_TARGET_HIT]  = path_control_mode &&
                                   target_reached;
    status_word[`SW_POS_LOAD_ACK] =
        (pos_r == stepper_status_pkg::POS_DONE);
    status_word[`SW_INPUT2] = din2 ^ feat2[`FEAT2_IN2_INV];
    status_word[`SW_INPUT1] = din1 ^ feat2[`FEAT2_IN1_INV];
  end

  property p_uv_off;
    @(posedge ref_clk) disable iff (!rst_n)
      supply_low |=> status_word[`SW_SUPPLY_LOW] && motor_off;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("supply_low_flag not flagged");
  property p_ot_off;
    @(posedge ref_clk) disable iff (!rst_n)
      driver_overtemp |=> status_word[`SW_OVERTEMP] && motor_off;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("overtemperature not flagged");
  property p_enc;
    @(posedge ref_clk) disable iff (!rst_n)
      encoder_enable |-> !status_word[`SW_ENC_LOCK];
  endproperty
  a_enc: assert property (p_enc)
    else $error("encoder lock set while enabled");
  property p_tgl;
    @(posedge ref_clk) disable iff (!rst_n)
      $changed(control_word[`CW_LATCH_REQ]) |=>
        status_word[`SW_LATCH_TGL] == $past(control_word[`CW_LATCH_REQ]);
  endproperty
  a_tgl: assert property (p_tgl)
    else $error("latch toggle ack missing");
  property p_page;
    @(posedge ref_clk) disable iff (!rst_n)
      page_r <= `PAGE_MAX;
  endproperty
  a_page: assert property (p_page)
    else $error("page select out of range");
  property p_tgt;
    @(posedge ref_clk) disable iff (!rst_n)
      path_control_mode == 1'b0 |-> !status_word[`SW_TARGET_HIT];
  endproperty
  a_tgt: assert property (p_tgt)
    else $error("target flag outside path control");
  property p_posack;
    @(posedge ref_clk) disable iff (!rst_n)
      status_word[`SW_POS_LOAD_ACK] |-> $past(pos_op_done, 1) ||
        $past(status_word[`SW_POS_LOAD_ACK], 1);
  endproperty
  a_posack: assert property (p_posack)
    else $error("position ack without completion");
  property p_in;
    @(posedge ref_clk) disable iff (!rst_n)
      status_word[`SW_INPUT1] == (din1 ^ paged_r[0][`FEAT2_IDX][14]) &&
      status_word[`SW_INPUT2] == (din2 ^ paged_r[0][`FEAT2_IDX][15]);
  endproperty
  a_in: assert property (p_in)
    else $error("digital input evaluation wrong");
  property p_ro;
    @(posedge ref_clk) disable iff (!rst_n)
      reg_req && reg_write && reg_addr == `REG_CODE_WORD - 6'h01 |=>
        $stable(code_r) && $stable(hwver_r);
  endproperty
  a_ro: assert property (p_ro)
    else $error("reserved write changed state");
endmodule
`default_nettype wire

/* File: hw/stepper_status_defines.svh */
// register numbers, field positions, reset values and status bit layout
`ifndef STEPPER_STATUS_DEFINES_SVH
`define STEPPER_STATUS_DEFINES_SVH
`define REG_ACT_POS_LO    6'h00
`define REG_ACT_POS_HI    6'h01
`define REG_TGT_POS_LO    6'h02
`define REG_TGT_POS_HI    6'h03
`define REG_PAGE_SELECT   6'h04
`define REG_LATCH_HI      6'h05
`define REG_TEMPERATURE   6'h06
`define REG_COMMAND       6'h07
`define REG_TYPE_ID       6'h08
`define REG_FW_VERSION    6'h09
`define REG_MUX_SHIFT     6'h0a
`define REG_SIG_CHAN      6'h0b
`define REG_MIN_DLEN      6'h0c
`define REG_DSTRUCT       6'h0d
`define REG_ALIGNMENT     6'h0f
`define REG_HW_VERSION    6'h10
`define REG_CODE_WORD     6'h1f
`define REG_PAGED_BASE    6'h20
`define PAGE_MAX          16'h0002
`define RST_PAGE_SELECT   16'h0000
`define RST_COMMAND       16'h0000
`define RST_ALIGNMENT     16'h7f80
`define RST_CODE_WORD     16'h0000
`define RST_HW_VERSION    16'h0000
`define VAL_MUX_SHIFT     16'h0128
`define VAL_SIG_CHAN      16'h0128
`define VAL_MIN_DLEN      16'h2828
`define VAL_DSTRUCT       16'h0004
`define FEAT1_IDX         5'h00
`define FEAT1_LATCH_ARRAY 9
`define FEAT1_LOCK_LOW    12
`define FEAT1_LOCK_HIGH   13
`define LATCH_COUNT_IDX   5'h05
`define RST_LATCH_COUNT   16'h0014
`define FEAT2_IDX         5'h14
`define FEAT2_IN1_INV     14
`define FEAT2_IN2_INV     15
`define CW_LATCH_EN0      0
`define CW_LATCH_EN3      3
`define CW_LATCH_EN4      4
`define CW_LATCH_REQ      6
`define CW_POS_LOAD       10
`define CW_POS_CLEAR      13
`define CB_ERR_ACK        6
`define SW_SUPPLY_LOW     9
`define SW_OVERTEMP       8
`define SW_ENC_LOCK       7
`define SW_LATCH_TGL      6
`define SW_LATCH_SHOWN    5
`define SW_LATCH_EVT      4
`define SW_TARGET_HIT     3
`define SW_POS_LOAD_ACK   2
`define SW_INPUT2         1
`define SW_INPUT1         0
`endif

/* File: hw/stepper_status_pkg.sv */
// types shared by the status and register bank
`default_nettype none
package stepper_status_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    POS_IDLE  = 3'b001,
    POS_WAIT  = 3'b010,
    POS_DONE  = 3'b100
  } pos_state_t;
endpackage
`default_nettype wire

/* File: hw/sticky_fault.sv */
// one latched fault indication with host acknowledge
`default_nettype none
module sticky_fault (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic cond,
  input  wire logic ack,
  output var  logic flag
);
  logic flag_r;
  logic flag_nxt;
  // condition still present keeps the flag: set wins over acknowledge
  always_comb begin
    flag_nxt = flag_r;
    if (ack) begin
      flag_nxt = 1'b0;
    end
    if (cond) begin
      flag_nxt = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag = flag_r;
endmodule
`default_nettype wire

/* File: tb/stepper_host_model.sv */
// coupler side model: register access and control outputs
`include "stepper_status_defines.svh"
`default_nettype none
module stepper_host_model (
  input  wire logic        ref_clk,
  input  wire logic        reg_ack,
  input  wire logic [15:0] reg_rdata,
  output var  logic        reg_req,
  output var  logic        reg_write,
  output var  logic [5:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  output var  logic [15:0] control_word,
  output var  logic [7:0]  control_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_req      = 1'b0;
    reg_write    = 1'b0;
    reg_addr     = 6'h00;
    reg_wdata    = 16'h0000;
    control_word = 16'h0000;
    control_byte = 8'h00;
  end

  // one access: request held until ack is seen, bounded wait
  task automatic xfer(input logic wr, input logic [5:0] a,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    q  = 16'h0000;
    @(negedge ref_clk);
    reg_req   = 1'b1;
    reg_write = wr;
    reg_addr  = a;
    reg_wdata = d;
    // ack seen here was set high by the preceding rising edge
    while (!ok && n < 4) begin
      @(negedge ref_clk);
      n++;
      if (reg_ack === 1'b1) begin
        ok = 1'b1;
        q  = reg_rdata;
      end
    end
    @(negedge ref_clk);
    reg_req   = 1'b0;
    // released lines show garbage so a stale value cannot pass
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // level bits of the cyclic control word, changed at once without waiting for a clock edge
  task automatic set_cw(input logic [15:0] v);
    control_word = v;
  endtask

  // latched faults only clear once the host acknowledges them
  task automatic ack_faults();
    @(negedge ref_clk);
    control_byte[`CB_ERR_ACK] = 1'b1;
    @(negedge ref_clk);
    control_byte[`CB_ERR_ACK] = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/stepper_status_and_register_map_tb_top.sv */
// self-checking bench for the status word and register map
`include "stepper_status_defines.svh"
`default_nettype none
module stepper_status_and_register_map_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] TYPE_ID = 16'h0abc; // arbitrary value
  localparam logic [15:0] FW_VER  = 16'h0101; // arbitrary value
  localparam logic [5:0]  RA [12] = '{`REG_PAGE_SELECT, `REG_COMMAND,
    `REG_ALIGNMENT, `REG_CODE_WORD, `REG_MUX_SHIFT, `REG_SIG_CHAN,
    `REG_MIN_DLEN, `REG_DSTRUCT, `REG_TYPE_ID, `REG_FW_VERSION, 6'h0e,
    `REG_HW_VERSION};
  localparam logic [15:0] RV [12] = '{`RST_PAGE_SELECT, `RST_COMMAND,
    `RST_ALIGNMENT, `RST_CODE_WORD, `VAL_MUX_SHIFT, `VAL_SIG_CHAN,
    `VAL_MIN_DLEN, `VAL_DSTRUCT, TYPE_ID, FW_VER, 16'h0000,
    `RST_HW_VERSION};

  logic        ref_clk;
  logic        rst_n;
  logic [15:0] control_word;
  logic [7:0]  control_byte;
  logic        path_control_mode;
  logic        supply_low;
  logic        driver_overtemp;
  logic        encoder_enable;
  logic        latch_input;
  logic        latch_event;
  logic        target_reached;
  logic        pos_op_done;
  logic [31:0] actual_pos;
  logic [15:0] temperature;
  logic        din1;
  logic        din2;
  logic        reg_req;
  logic        reg_write;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_ack;
  logic [15:0] status_word;
  logic [15:0] data_bytes23;
  logic        motor_off;
  logic        pos_clear;
  logic        pos_load;
  logic [31:0] pos_load_value;
  int          error_cnt;
  int          total_checks;

  stepper_status_bank #(.TYPE_ID(TYPE_ID), .FW_VERSION(FW_VER))
    i_stepper_status_bank (.ref_clk(ref_clk), .rst_n(rst_n),
    .control_word(control_word), .control_byte(control_byte),
    .path_control_mode(path_control_mode), .supply_low(supply_low),
    .driver_overtemp(driver_overtemp), .encoder_enable(encoder_enable),
    .latch_input(latch_input), .latch_event(latch_event),
    .target_reached(target_reached), .pos_op_done(pos_op_done),
    .actual_pos(actual_pos), .temperature(temperature), .din1(din1),
    .din2(din2), .reg_req(reg_req), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .status_word(status_word),
    .data_bytes23(data_bytes23), .motor_off(motor_off),
    .pos_clear(pos_clear), .pos_load(pos_load),
    .pos_load_value(pos_load_value));

  stepper_host_model i_stepper_host_model (.ref_clk(ref_clk),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .control_word(control_word), .control_byte(control_byte));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic sw(input int b, input logic e);
    check({31'h0, status_word[b]}, {31'h0, e});
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    i_stepper_host_model.xfer(1'b1, a, d, q, ok);
    check({31'h0, ok}, 32'h1);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic        ok;
    i_stepper_host_model.xfer(1'b0, a, 16'h0000, q, ok);
    check({31'h0, ok}, 32'h1);
    check({16'h0, q}, {16'h0, exp});
  endtask

  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end

  initial begin
    error_cnt = 0;
    total_checks = 0;
    rst_n = 1'b0;
    {path_control_mode, supply_low, driver_overtemp, encoder_enable} = 4'h0;
    {latch_input, latch_event, target_reached, pos_op_done} = 4'h0;
    actual_pos = 32'hcafe_1234;
    temperature = 16'h003c;
    din1 = 1'b1;
    din2 = 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 12; i++) rd_chk(RA[i], RV[i]);
    for (int i = 4; i < 11; i++) begin
      wr(RA[i], 16'h5a5a);
      rd_chk(RA[i], RV[i]);
    end
    wr(6'h1e, 16'h5a5a);
    rd_chk(6'h1e, 16'h0000);
    for (int i = 1; i < 4; i++) begin
      wr(RA[i], 16'h1230 + 16'(i));
      rd_chk(RA[i], 16'h1230 + 16'(i));
    end
    rd_chk(`REG_ACT_POS_LO, 16'h1234);
    rd_chk(`REG_ACT_POS_HI, 16'hcafe);
    rd_chk(`REG_TEMPERATURE, 16'h003c);
    wr(`REG_TGT_POS_LO, 16'h3344);
    wr(`REG_TGT_POS_HI, 16'h1122);
    rd_chk(`REG_TGT_POS_LO, 16'h3344);
    rd_chk(`REG_TGT_POS_HI, 16'h1122);
    check(pos_load_value, 32'h1122_3344);
    // paged window: same number, different contents per page
    rd_chk(6'h25, `RST_LATCH_COUNT);
    wr(`REG_PAGE_SELECT, 16'h0001);
    wr(6'h25, 16'h0777);
    rd_chk(6'h25, 16'h0777);
    wr(`REG_PAGE_SELECT, 16'h0003);
    rd_chk(`REG_PAGE_SELECT, 16'h0001);
    wr(`REG_PAGE_SELECT, `PAGE_MAX);
    rd_chk(`REG_PAGE_SELECT, `PAGE_MAX);
    wr(`REG_PAGE_SELECT, 16'h0000);
    rd_chk(6'h25, `RST_LATCH_COUNT);
    sw(`SW_INPUT1, 1'b1);
    sw(`SW_INPUT2, 1'b0);
    wr(6'h34, 16'hc000);
    sw(`SW_INPUT1, 1'b0);
    sw(`SW_INPUT2, 1'b1);
    wr(6'h34, 16'h0000);
    encoder_enable = 1'b1;
    tick(1);
    sw(`SW_ENC_LOCK, 1'b0);
    encoder_enable = 1'b0;
    wr(6'h20, 16'h1000);
    sw(`SW_ENC_LOCK, 1'b1);
    latch_input = 1'b1;
    tick(1);
    sw(`SW_ENC_LOCK, 1'b0);
    wr(6'h20, 16'h2000);
    sw(`SW_ENC_LOCK, 1'b1);
    wr(6'h20, 16'h0000);
    // a fault outlives its cause until acknowledged
    for (int f = 0; f < 2; f++) begin
      if (f == 0) supply_low = 1'b1;
      else driver_overtemp = 1'b1;
      tick(1);
      sw(`SW_SUPPLY_LOW - f, 1'b1);
      check({31'h0, motor_off}, 32'h1);
      {supply_low, driver_overtemp} = 2'b00;
      tick(2);
      sw(`SW_SUPPLY_LOW - f, 1'b1);
      i_stepper_host_model.ack_faults();
      sw(`SW_SUPPLY_LOW - f, 1'b0);
      check({31'h0, motor_off}, 32'h0);
    end
    i_stepper_host_model.set_cw(16'h0001);
    actual_pos = 32'habcd_5678;
    latch_event = 1'b1;
    tick(1);
    latch_event = 1'b0;
    actual_pos = 32'h1111_2222;
    tick(1);
    sw(`SW_LATCH_EVT, 1'b1);
    check({16'h0, data_bytes23}, 32'h2222);
    i_stepper_host_model.set_cw(16'h0041);
    tick(1);
    sw(`SW_LATCH_TGL, 1'b1);
    sw(`SW_LATCH_SHOWN, 1'b1);
    check({16'h0, data_bytes23}, 32'h5678);
    rd_chk(`REG_LATCH_HI, 16'habcd);
    i_stepper_host_model.set_cw(16'h0001);
    tick(1);
    sw(`SW_LATCH_TGL, 1'b0);
    sw(`SW_LATCH_SHOWN, 1'b0);
    check({16'h0, data_bytes23}, 32'h2222);
    i_stepper_host_model.set_cw(16'h0000);
    tick(1);
    sw(`SW_LATCH_EVT, 1'b0);
    // latch array: flag only once the configured count is stored
    wr(6'h25, 16'h0002);
    wr(6'h20, 16'h0200);
    i_stepper_host_model.set_cw(16'h0008);
    for (int k = 0; k < 2; k++) begin
      latch_event = 1'b1;
      tick(1);
      latch_event = 1'b0;
      tick(1);
      sw(`SW_LATCH_EVT, k[0]);
    end
    i_stepper_host_model.set_cw(16'h0000);
    wr(6'h20, 16'h0000);
    target_reached = 1'b1;
    tick(1);
    sw(`SW_TARGET_HIT, 1'b0);
    path_control_mode = 1'b1;
    tick(1);
    sw(`SW_TARGET_HIT, 1'b1);
    target_reached = 1'b0;
    tick(1);
    sw(`SW_TARGET_HIT, 1'b0);
    // clear first, then load; each waits for the done pulse
    for (int c = 0; c < 2; c++) begin
      i_stepper_host_model.set_cw(c == 0 ? 16'h2000 : 16'h0400);
      tick(1);
      check({31'h0, c == 0 ? pos_clear : pos_load}, 32'h1);
      sw(`SW_POS_LOAD_ACK, 1'b0);
      pos_op_done = 1'b1;
      tick(1);
      pos_op_done = 1'b0;
      sw(`SW_POS_LOAD_ACK, 1'b1);
      i_stepper_host_model.set_cw(16'h0000);
      tick(1);
      sw(`SW_POS_LOAD_ACK, 1'b0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
